// *** pkg/iotsd_pkg.sv ***
// Constants, carriers and helpers for the terminal status display
package iotsd_pkg;

   // Timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int RATE_GATE_NS = 1_000_000_000;
   localparam int RATE_GATE_CYCLES = RATE_GATE_NS / CLK_PERIOD_NS;

   // Widths and counts
   localparam int GENERAL_INPUTS = 9;
   localparam int TRANSISTOR_OUTPUTS = 4;
   localparam int LOGIC_STEPS = 16;
   localparam int RATE_WIDTH = 32;

   // Input status word bit positions
   localparam int IN_FORWARD_BIT = 0;
   localparam int IN_REVERSE_BIT = 1;
   localparam int IN_GENERAL_LSB = 2;
   localparam int IN_COMM_FORWARD_BIT = 13;
   localparam int IN_COMM_REVERSE_BIT = 14;
   localparam int IN_COMM_RESET_BIT = 15;

   // Output status word bit positions
   localparam int OUT_TRANSISTOR_LSB = 0;
   localparam int OUT_SECOND_RELAY_BIT = 4;
   localparam int OUT_ALARM_RELAY_BIT = 8;

   // Segment positions within a digit byte
   localparam int SEG_A = 0;
   localparam int SEG_B = 1;
   localparam int SEG_C = 2;
   localparam int SEG_D = 3;
   localparam int SEG_E = 4;
   localparam int SEG_F = 5;
   localparam int SEG_G = 6;
   localparam int SEG_DP = 7;

   // Reset values
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [7:0] DIGIT_RESET = 8'h00;
   localparam logic [7:0] DIGIT_DASH = 8'h40;
   localparam logic [31:0] RATE_RESET = 32'h0000_0000;
   localparam logic [15:0] RATE_SATURATE = 16'hffff;

   typedef logic [15:0] iotsd_word_t;

   // Physical terminal contact states, one when closed
   typedef struct packed {
      logic alarm_relay_contact;
      logic second_relay_contact;
      logic [TRANSISTOR_OUTPUTS-1:0] transistor_output;
      logic [GENERAL_INPUTS-1:0] general_input;
      logic reverse_run_input;
      logic forward_run_input;
   } iotsd_term_t;

   // Commands received over communications
   typedef struct packed {
      logic comm_reset_command;
      logic comm_reverse_command;
      logic comm_forward_command;
   } iotsd_comm_t;

   // Encoder feedback levels
   typedef struct packed {
      logic slave_index;
      logic slave_quadrature;
      logic reference_index;
   } iotsd_enc_t;

   typedef enum logic [2:0] {
      ITEM_TERMINALS = 3'b000,
      ITEM_TERMINALS_COMM = 3'b001,
      ITEM_REF_INDEX_RATE = 3'b010,
      ITEM_SLAVE_QUAD_RATE = 3'b011,
      ITEM_SLAVE_INDEX_RATE = 3'b100,
      ITEM_LOGIC_TIMER = 3'b101
   } iotsd_item_t;

   typedef enum logic [1:0] {
      VIEW_SEGMENT = 2'b00,
      VIEW_HEX_INPUT = 2'b01,
      VIEW_HEX_OUTPUT = 2'b10
   } iotsd_view_t;

   // Hex nibble to segments, bit 0 is segment a
   function automatic logic [7:0] hex_segments(input logic [3:0] n);
      logic [7:0] s;
      s = 8'h00;
      case (n)
         4'h0: s = 8'h3f;
         4'h1: s = 8'h06;
         4'h2: s = 8'h5b;
         4'h3: s = 8'h4f;
         4'h4: s = 8'h66;
         4'h5: s = 8'h6d;
         4'h6: s = 8'h7d;
         4'h7: s = 8'h07;
         4'h8: s = 8'h7f;
         4'h9: s = 8'h6f;
         4'ha: s = 8'h77;
         4'hb: s = 8'h7c;
         4'hc: s = 8'h39;
         4'hd: s = 8'h5e;
         4'he: s = 8'h79;
         default: s = 8'h71;
      endcase
      return s;
   endfunction

endpackage

// *** design/iotsd_sync.sv ***
// Two-stage synchroniser for a group of level inputs
module iotsd_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Levels
   input wire logic [WIDTH-1:0] level_in,
   output logic [WIDTH-1:0] level_out
);

   logic [WIDTH-1:0] stage_one;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stage_one <= '0;
         level_out <= '0;
      end else begin
         stage_one <= level_in;
         level_out <= stage_one;
      end
   end

endmodule

// *** design/iotsd_rate.sv ***
// Counts rising edges of one synchronised level over each gate period
module iotsd_rate (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Pulse level and gate
   input wire logic pulse_level,
   input wire logic gate_tick,
   // Pulses in the last full gate period
   output logic [iotsd_pkg::RATE_WIDTH-1:0] rate
);

   logic previous;
   logic rising;
   logic [iotsd_pkg::RATE_WIDTH-1:0] count;
   logic [iotsd_pkg::RATE_WIDTH-1:0] next_count;

   assign rising = pulse_level & ~previous;
   assign next_count = count + {{(iotsd_pkg::RATE_WIDTH-1){1'b0}}, rising};

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         previous <= 1'b0;
         count <= iotsd_pkg::RATE_RESET;
         rate <= iotsd_pkg::RATE_RESET;
      end else begin
         previous <= pulse_level;
         if (gate_tick) begin
            rate <= next_count;
            count <= iotsd_pkg::RATE_RESET;
         end else begin
            count <= next_count;
         end
      end
   end

endmodule

// *** design/iotsd_top.sv ***
// Terminal status word builder and four-digit monitor driver
module iotsd_top #(
   parameter int GATE_CYCLES = iotsd_pkg::RATE_GATE_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Terminal contacts and commands
   input wire iotsd_pkg::iotsd_term_t terminals,
   input wire iotsd_pkg::iotsd_comm_t comm_commands,
   input wire iotsd_pkg::iotsd_enc_t encoders,
   // Configuration
   input wire logic [10:0] input_invert,
   input wire iotsd_pkg::iotsd_item_t display_item,
   input wire iotsd_pkg::iotsd_view_t display_view,
   input wire logic [3:0] logic_timer_select,
   input wire iotsd_pkg::iotsd_word_t [iotsd_pkg::LOGIC_STEPS-1:0] step_values,
   // Monitor digits, bit 0 segment a, bit 7 dp
   output logic [7:0] digit_lowest,
   output logic [7:0] digit_second,
   output logic [7:0] digit_third,
   output logic [7:0] digit_highest,
   // Status words and shown value
   output iotsd_pkg::iotsd_word_t input_status,
   output iotsd_pkg::iotsd_word_t output_status,
   output iotsd_pkg::iotsd_word_t shown_value
);

   localparam int TERM_W = $bits(iotsd_pkg::iotsd_term_t);
   localparam int COMM_W = $bits(iotsd_pkg::iotsd_comm_t);
   localparam int ENC_W = $bits(iotsd_pkg::iotsd_enc_t);
   // Gate length is a parameter so simulation can shorten it
   localparam logic [31:0] GATE_LAST = 32'(GATE_CYCLES - 1);

   // Synchronised terminal, command and encoder levels
   iotsd_pkg::iotsd_term_t term_s;
   iotsd_pkg::iotsd_comm_t comm_s;
   iotsd_pkg::iotsd_enc_t enc_s;

   // Synchronised copies of the terminal, command and encoder levels; configuration inputs are not synchronised
   // Pulses shorter than one clock may be lost on the way in
   iotsd_sync #(.WIDTH(TERM_W)) u_sync_term (
      .clk(clk),
      .rst_b(rst_b),
      .level_in(terminals),
      .level_out(term_s)
   );

   iotsd_sync #(.WIDTH(COMM_W)) u_sync_comm (
      .clk(clk),
      .rst_b(rst_b),
      .level_in(comm_commands),
      .level_out(comm_s)
   );

   iotsd_sync #(.WIDTH(ENC_W)) u_sync_enc (
      .clk(clk),
      .rst_b(rst_b),
      .level_in(encoders),
      .level_out(enc_s)
   );

   // One-second gate for the pulse rate counters
   logic [31:0] gate_count;
   logic [31:0] next_gate_count;
   logic gate_tick;

   // All three counters share one gate, so their windows line up
   assign gate_tick = (gate_count == GATE_LAST);
   assign next_gate_count = gate_tick ? 32'h0000_0000
                                      : gate_count + 32'h0000_0001;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gate_count <= 32'h0000_0000;
      end else begin
         gate_count <= next_gate_count;
      end
   end

   // Latched counts, one full gate old
   logic [iotsd_pkg::RATE_WIDTH-1:0] ref_index_rate;
   logic [iotsd_pkg::RATE_WIDTH-1:0] slave_quad_rate;
   logic [iotsd_pkg::RATE_WIDTH-1:0] slave_index_rate;

   // Reference encoder index pulses per second
   iotsd_rate u_rate_ref_index (
      .clk(clk),
      .rst_b(rst_b),
      .pulse_level(enc_s.reference_index),
      .gate_tick(gate_tick),
      .rate(ref_index_rate)
   );

   // Slave encoder quadrature pulses per second
   iotsd_rate u_rate_slave_quad (
      .clk(clk),
      .rst_b(rst_b),
      .pulse_level(enc_s.slave_quadrature),
      .gate_tick(gate_tick),
      .rate(slave_quad_rate)
   );

   // Slave encoder index pulses per second
   iotsd_rate u_rate_slave_index (
      .clk(clk),
      .rst_b(rst_b),
      .pulse_level(enc_s.slave_index),
      .gate_tick(gate_tick),
      .rate(slave_index_rate)
   );

   // Physical inputs, with configured inversion or true logic
   wire comm_item = (display_item == iotsd_pkg::ITEM_TERMINALS_COMM);
   wire [10:0] raw_inputs = {term_s.general_input,
                             term_s.reverse_run_input,
                             term_s.forward_run_input};
   // Inversion setting is used as it stands, without synchronising
   // Communications view ignores terminal inversion
   wire [10:0] shown_inputs = comm_item ? raw_inputs
                                        : (raw_inputs ^ input_invert);
   wire [2:0] comm_levels = {comm_s.comm_reset_command,
                             comm_s.comm_reverse_command,
                             comm_s.comm_forward_command};
   // Command bits read as zero outside the communications item
   wire [2:0] shown_comm = comm_item ? comm_levels : 3'h0;

   // Input status word
   iotsd_pkg::iotsd_word_t next_input_status;
   always_comb begin
      next_input_status = iotsd_pkg::WORD_RESET;
      next_input_status[iotsd_pkg::IN_FORWARD_BIT] = shown_inputs[0];
      next_input_status[iotsd_pkg::IN_REVERSE_BIT] = shown_inputs[1];
      next_input_status[iotsd_pkg::IN_GENERAL_LSB +: iotsd_pkg::GENERAL_INPUTS] =
         shown_inputs[10:2];
      // Bits 11 and 12 have no terminal and stay zero
      next_input_status[iotsd_pkg::IN_COMM_FORWARD_BIT] = shown_comm[0];
      next_input_status[iotsd_pkg::IN_COMM_REVERSE_BIT] = shown_comm[1];
      next_input_status[iotsd_pkg::IN_COMM_RESET_BIT] = shown_comm[2];
   end

   // Output status word
   iotsd_pkg::iotsd_word_t next_output_status;
   always_comb begin
      next_output_status = iotsd_pkg::WORD_RESET;
      next_output_status[iotsd_pkg::OUT_TRANSISTOR_LSB +:
                         iotsd_pkg::TRANSISTOR_OUTPUTS] =
         term_s.transistor_output;
      // Unassigned bits keep the zero from the reset value
      next_output_status[iotsd_pkg::OUT_SECOND_RELAY_BIT] =
         term_s.second_relay_contact;
      next_output_status[iotsd_pkg::OUT_ALARM_RELAY_BIT] =
         term_s.alarm_relay_contact;
   end

   // Segment view, one segment per terminal
   logic [7:0] seg_lowest;
   logic [7:0] seg_second;
   logic [7:0] seg_third;
   logic [7:0] seg_highest;
   wire all_off = (next_input_status == iotsd_pkg::WORD_RESET) &&
                  (next_output_status == iotsd_pkg::WORD_RESET);

   always_comb begin
      // Lowest digit: run inputs on a and b, general one to six above
      seg_lowest = iotsd_pkg::DIGIT_RESET;
      seg_lowest[iotsd_pkg::SEG_A] = next_input_status[0];
      seg_lowest[iotsd_pkg::SEG_B] = next_input_status[1];
      seg_lowest[iotsd_pkg::SEG_C] = next_input_status[2];
      seg_lowest[iotsd_pkg::SEG_D] = next_input_status[3];
      seg_lowest[iotsd_pkg::SEG_E] = next_input_status[4];
      seg_lowest[iotsd_pkg::SEG_F] = next_input_status[5];
      seg_lowest[iotsd_pkg::SEG_G] = next_input_status[6];
      seg_lowest[iotsd_pkg::SEG_DP] = next_input_status[7];

      // Second digit: general seven to nine, then the command bits
      seg_second = iotsd_pkg::DIGIT_RESET;
      seg_second[iotsd_pkg::SEG_A] = next_input_status[8];
      seg_second[iotsd_pkg::SEG_B] = next_input_status[9];
      seg_second[iotsd_pkg::SEG_C] = next_input_status[10];
      seg_second[iotsd_pkg::SEG_F] =
         next_input_status[iotsd_pkg::IN_COMM_FORWARD_BIT];
      seg_second[iotsd_pkg::SEG_G] =
         next_input_status[iotsd_pkg::IN_COMM_REVERSE_BIT];
      seg_second[iotsd_pkg::SEG_DP] =
         next_input_status[iotsd_pkg::IN_COMM_RESET_BIT];

      // Third digit: transistor outputs, then the second relay
      seg_third = iotsd_pkg::DIGIT_RESET;
      seg_third[iotsd_pkg::SEG_A +: iotsd_pkg::TRANSISTOR_OUTPUTS] =
         term_s.transistor_output;
      seg_third[iotsd_pkg::SEG_E] = term_s.second_relay_contact;

      // Highest digit: alarm relay only
      seg_highest = iotsd_pkg::DIGIT_RESET;
      seg_highest[iotsd_pkg::SEG_A] = term_s.alarm_relay_contact;

      // Dashes only when both words are empty, judged after inversion
      if (all_off) begin
         seg_lowest = iotsd_pkg::DIGIT_DASH;
         seg_second = iotsd_pkg::DIGIT_DASH;
         seg_third = iotsd_pkg::DIGIT_DASH;
         seg_highest = iotsd_pkg::DIGIT_DASH;
      end
   end

   // Value for hex rendering
   function automatic iotsd_pkg::iotsd_word_t clip
      (input logic [iotsd_pkg::RATE_WIDTH-1:0] r);
      return (r > {16'h0000, iotsd_pkg::RATE_SATURATE}) ?
             iotsd_pkg::RATE_SATURATE : r[15:0];
   endfunction

   wire terminal_item = (display_item == iotsd_pkg::ITEM_TERMINALS) ||
                        comm_item;
   // Step values are taken as they stand, no synchronisation
   wire iotsd_pkg::iotsd_word_t timer_value =
      step_values[logic_timer_select];
   iotsd_pkg::iotsd_word_t next_shown;

   // Rates wider than four hex digits are pinned at ffff, not wrapped
   wire iotsd_pkg::iotsd_word_t ref_index_shown = clip(ref_index_rate);
   wire iotsd_pkg::iotsd_word_t slave_quad_shown = clip(slave_quad_rate);
   wire iotsd_pkg::iotsd_word_t slave_index_shown = clip(slave_index_rate);
   // View 3 is not defined and falls back to the input word
   wire hex_output_view = (display_view == iotsd_pkg::VIEW_HEX_OUTPUT);
   wire iotsd_pkg::iotsd_word_t terminal_word =
      hex_output_view ? next_output_status : next_input_status;

   always_comb begin
      case (display_item)
         iotsd_pkg::ITEM_TERMINALS,
         iotsd_pkg::ITEM_TERMINALS_COMM: begin
            next_shown = terminal_word;
         end
         iotsd_pkg::ITEM_REF_INDEX_RATE: begin
            next_shown = ref_index_shown;
         end
         iotsd_pkg::ITEM_SLAVE_QUAD_RATE: begin
            next_shown = slave_quad_shown;
         end
         iotsd_pkg::ITEM_SLAVE_INDEX_RATE: begin
            next_shown = slave_index_shown;
         end
         iotsd_pkg::ITEM_LOGIC_TIMER: begin
            next_shown = timer_value;
         end
         default: begin
            next_shown = iotsd_pkg::WORD_RESET;
         end
      endcase
   end

   // Segment view only for terminal items; others always hex
   wire use_segments = terminal_item &&
                       (display_view == iotsd_pkg::VIEW_SEGMENT);
   // Most significant nibble on the highest digit
   wire [7:0] hex_lowest = iotsd_pkg::hex_segments(next_shown[3:0]);
   wire [7:0] hex_second = iotsd_pkg::hex_segments(next_shown[7:4]);
   wire [7:0] hex_third = iotsd_pkg::hex_segments(next_shown[11:8]);
   wire [7:0] hex_highest = iotsd_pkg::hex_segments(next_shown[15:12]);

   wire [7:0] next_lowest = use_segments ? seg_lowest : hex_lowest;
   wire [7:0] next_second = use_segments ? seg_second : hex_second;
   wire [7:0] next_third = use_segments ? seg_third : hex_third;
   wire [7:0] next_highest = use_segments ? seg_highest : hex_highest;

   // Registered digits, refreshed every clock
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         digit_lowest <= iotsd_pkg::DIGIT_RESET;
         digit_second <= iotsd_pkg::DIGIT_RESET;
         digit_third <= iotsd_pkg::DIGIT_RESET;
         digit_highest <= iotsd_pkg::DIGIT_RESET;
      end else begin
         digit_lowest <= next_lowest;
         digit_second <= next_second;
         digit_third <= next_third;
         digit_highest <= next_highest;
      end
   end

   // Registered status words
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         input_status <= iotsd_pkg::WORD_RESET;
         output_status <= iotsd_pkg::WORD_RESET;
      end else begin
         input_status <= next_input_status;
         output_status <= next_output_status;
      end
   end

   // Registered value behind the hex rendering
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         shown_value <= iotsd_pkg::WORD_RESET;
      end else begin
         shown_value <= next_shown;
      end
   end

endmodule

// *** sim/iotsd_top_monitor.sv ***
// Port checker for the terminal status display
module iotsd_top_monitor #(
   parameter int GATE_CYCLES = 10
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Inputs watched
   input wire iotsd_pkg::iotsd_term_t terminals,
   input wire iotsd_pkg::iotsd_comm_t comm_commands,
   input wire iotsd_pkg::iotsd_item_t display_item,
   input wire iotsd_pkg::iotsd_view_t display_view,
   input wire logic [3:0] logic_timer_select,
   input wire iotsd_pkg::iotsd_word_t [iotsd_pkg::LOGIC_STEPS-1:0]
      step_values,
   // Outputs watched
   input wire logic [7:0] digit_lowest,
   input wire logic [7:0] digit_second,
   input wire logic [7:0] digit_third,
   input wire logic [7:0] digit_highest,
   input wire iotsd_pkg::iotsd_word_t input_status,
   input wire iotsd_pkg::iotsd_word_t output_status,
   input wire iotsd_pkg::iotsd_word_t shown_value
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] up;
   logic ok;
   iotsd_pkg::iotsd_word_t sel_val;
   // Past values are trusted only once the pipeline has refilled
   assign ok = up == 3'h4;
   assign sel_val = step_values[logic_timer_select];
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         up <= 3'h0;
      end else if (!ok) begin
         up <= up + 3'h1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_term_cfg;
      ok && ($past(display_item) == iotsd_pkg::ITEM_TERMINALS ||
         $past(display_item) == iotsd_pkg::ITEM_TERMINALS_COMM);
   endsequence
   sequence s_seg_cfg;
      s_term_cfg ##0 $past(display_view) == iotsd_pkg::VIEW_SEGMENT;
   endsequence
   sequence s_comm_cfg;
      ok && $past(display_item) == iotsd_pkg::ITEM_TERMINALS_COMM;
   endsequence
   property p_in_word;
      s_comm_cfg |-> input_status[12:0] == {2'b00, $past(terminals[10:0], 3)};
   endproperty
   a_in_word: assert property (p_in_word)
      else $error("input word differs from terminals");
   property p_comm;
      s_comm_cfg |-> input_status[15:13] == $past(comm_commands, 3);
   endproperty
   a_comm: assert property (p_comm)
      else $error("command bits differ");
   property p_comm_off;
      ok && $past(display_item) != iotsd_pkg::ITEM_TERMINALS_COMM
         |-> input_status[15:13] == 3'h0;
   endproperty
   a_comm_off: assert property (p_comm_off)
      else $error("command bits shown outside command item");
   property p_out_word;
      ok |-> output_status == {7'h00, $past(terminals[16], 3), 3'h0,
         $past(terminals[15:11], 3)};
   endproperty
   a_out_word: assert property (p_out_word)
      else $error("output word differs from contacts");
   property p_dash;
      s_seg_cfg ##0 (input_status == 16'h0000 && output_status == 16'h0000)
         |-> {digit_highest, digit_third, digit_second, digit_lowest}
         == 32'h40404040;
   endproperty
   a_dash: assert property (p_dash)
      else $error("dash row missing");
   property p_seg_map;
      s_seg_cfg ##0 (input_status != 16'h0000 || output_status != 16'h0000)
         |-> digit_lowest == input_status[7:0] && digit_second ==
         {input_status[15:13], 2'b00, input_status[10:8]} &&
         digit_third == {3'h0, output_status[4:0]} &&
         digit_highest == {7'h00, output_status[8]};
   endproperty
   a_seg_map: assert property (p_seg_map)
      else $error("segment map wrong");
   property p_hex_src;
      s_term_cfg ##0 $past(display_view) != iotsd_pkg::VIEW_SEGMENT
         |-> shown_value == ($past(display_view) == iotsd_pkg::VIEW_HEX_OUTPUT
         ? output_status : input_status);
   endproperty
   a_hex_src: assert property (p_hex_src)
      else $error("hex value source wrong");
   property p_timer;
      ok && $past(display_item) == iotsd_pkg::ITEM_LOGIC_TIMER
         |-> shown_value == $past(sel_val);
   endproperty
   a_timer: assert property (p_timer)
      else $error("timer value wrong");
endmodule

bind iotsd_top iotsd_top_monitor #(.GATE_CYCLES(GATE_CYCLES)) u_mon (
   .clk(clk), .rst_b(rst_b), .terminals(terminals),
   .comm_commands(comm_commands), .display_item(display_item),
   .display_view(display_view), .logic_timer_select(logic_timer_select),
   .step_values(step_values), .digit_lowest(digit_lowest),
   .digit_second(digit_second), .digit_third(digit_third),
   .digit_highest(digit_highest), .input_status(input_status),
   .output_status(output_status), .shown_value(shown_value));

// *** sim/iotsd_far.sv ***
// Model of the terminal contacts, command source and encoders
module iotsd_far (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Requested contact states and encoder enables
   input wire iotsd_pkg::iotsd_term_t term_set,
   input wire iotsd_pkg::iotsd_comm_t comm_set,
   input wire logic [2:0] enc_en,
   // Lines into the block
   output iotsd_pkg::iotsd_term_t terminals,
   output iotsd_pkg::iotsd_comm_t comm_commands,
   output iotsd_pkg::iotsd_enc_t encoders
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [5:0] cnt;
   logic [2:0] wave;
   // Periods 4, 8 and 10 clocks all divide a 40-cycle frame
   assign wave = {(cnt % 6'h0a) >= 6'h05, cnt[2], cnt[1]};
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 6'h00;
         terminals <= '0;
         comm_commands <= '0;
         encoders <= '0;
      end else begin
         cnt <= (cnt == 6'h27) ? 6'h00 : cnt + 6'h01;
         terminals <= term_set;
         comm_commands <= comm_set;
         encoders <= iotsd_pkg::iotsd_enc_t'(wave & enc_en);
      end
   end
endmodule

// *** sim/iotsd_top_test.sv ***
// Self-checking bench for the terminal status display
module iotsd_top_test;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int GATE = 40;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   iotsd_pkg::iotsd_term_t term_set = '0;
   iotsd_pkg::iotsd_comm_t comm_set = '0;
   logic [2:0] enc_en = 3'h0;
   iotsd_pkg::iotsd_term_t terminals;
   iotsd_pkg::iotsd_comm_t comm_commands;
   iotsd_pkg::iotsd_enc_t encoders;
   logic [10:0] input_invert = 11'h000;
   iotsd_pkg::iotsd_item_t display_item = iotsd_pkg::ITEM_TERMINALS;
   iotsd_pkg::iotsd_view_t display_view = iotsd_pkg::VIEW_SEGMENT;
   logic [3:0] logic_timer_select = 4'h0;
   iotsd_pkg::iotsd_word_t [iotsd_pkg::LOGIC_STEPS-1:0] step_values = '0;
   logic [7:0] digit_lowest;
   logic [7:0] digit_second;
   logic [7:0] digit_third;
   logic [7:0] digit_highest;
   iotsd_pkg::iotsd_word_t input_status;
   iotsd_pkg::iotsd_word_t output_status;
   iotsd_pkg::iotsd_word_t shown_value;
   logic [31:0] all_digits;
   int n_fail = 0;
   int checks_done = 0;
   assign all_digits = {digit_highest, digit_third, digit_second, digit_lowest};
   always #2.5 clk = ~clk;
   iotsd_far u_far (.clk(clk), .rst_b(rst_b), .term_set(term_set),
      .comm_set(comm_set), .enc_en(enc_en), .terminals(terminals),
      .comm_commands(comm_commands), .encoders(encoders));
   iotsd_top #(.GATE_CYCLES(GATE)) u_dut (.clk(clk), .rst_b(rst_b),
      .terminals(terminals), .comm_commands(comm_commands),
      .encoders(encoders), .input_invert(input_invert),
      .display_item(display_item), .display_view(display_view),
      .logic_timer_select(logic_timer_select), .step_values(step_values),
      .digit_lowest(digit_lowest), .digit_second(digit_second),
      .digit_third(digit_third), .digit_highest(digit_highest),
      .input_status(input_status), .output_status(output_status),
      .shown_value(shown_value));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One partner register plus three design flops, with margin
   task automatic setup(input logic [16:0] t, input logic [2:0] c,
      input iotsd_pkg::iotsd_item_t it, input iotsd_pkg::iotsd_view_t v);
      @(posedge clk);
      term_set <= t;
      comm_set <= c;
      display_item <= it;
      display_view <= v;
      repeat (6) @(posedge clk);
      #1;
   endtask
   task automatic t_status();
      setup('0, 3'h0, iotsd_pkg::ITEM_TERMINALS, iotsd_pkg::VIEW_SEGMENT);
      chk(all_digits, 32'h40404040);
      for (int i = 0; i < 11; i++) begin
         setup(17'h1 << i, 3'h0, iotsd_pkg::ITEM_TERMINALS,
            iotsd_pkg::VIEW_SEGMENT);
         chk(input_status, 32'h1 << i);
         chk({digit_second[2:0], digit_lowest}, 32'h1 << i);
         chk({digit_highest, digit_third}, 32'h0);
      end
      for (int k = 0; k < 6; k++) begin
         setup(17'h800 << k, 3'h0, iotsd_pkg::ITEM_TERMINALS,
            iotsd_pkg::VIEW_SEGMENT);
         chk(output_status, k < 5 ? 32'h1 << k : 32'h100);
         chk({digit_highest[0], digit_third[4:0]}, 32'h1 << k);
         chk(input_status, 32'h0);
      end
      $display("test status done");
   endtask
   task automatic t_comm();
      for (int j = 0; j < 3; j++) begin
         setup('0, 3'h1 << j, iotsd_pkg::ITEM_TERMINALS_COMM,
            iotsd_pkg::VIEW_SEGMENT);
         chk(input_status, 32'h2000 << j);
         chk(digit_second, 32'h20 << j);
      end
      setup(17'h7ff, 3'h7, iotsd_pkg::ITEM_TERMINALS_COMM,
         iotsd_pkg::VIEW_HEX_INPUT);
      chk(all_digits, 32'h79077171);
      setup(17'h7ff, 3'h7, iotsd_pkg::ITEM_TERMINALS, iotsd_pkg::VIEW_HEX_INPUT);
      chk(all_digits, 32'h3f077171);
      $display("test comm done");
   endtask
   task automatic t_hex();
      setup(17'h5, 3'h0, iotsd_pkg::ITEM_TERMINALS, iotsd_pkg::VIEW_HEX_INPUT);
      chk(all_digits, 32'h3f3f3f6d);
      setup(17'h10800, 3'h0, iotsd_pkg::ITEM_TERMINALS,
         iotsd_pkg::VIEW_HEX_OUTPUT);
      chk(all_digits, 32'h3f063f06);
      @(posedge clk);
      input_invert <= 11'h001;
      setup('0, 3'h0, iotsd_pkg::ITEM_TERMINALS, iotsd_pkg::VIEW_HEX_INPUT);
      chk(input_status, 32'h1);
      setup('0, 3'h0, iotsd_pkg::ITEM_TERMINALS_COMM,
         iotsd_pkg::VIEW_HEX_INPUT);
      chk(input_status, 32'h0);
      @(posedge clk);
      input_invert <= 11'h000;
      $display("test hex done");
   endtask
   task automatic t_rates();
      @(posedge clk);
      enc_en <= 3'h7;
      repeat (4 * GATE) @(posedge clk);
      setup('0, 3'h0, iotsd_pkg::ITEM_REF_INDEX_RATE, iotsd_pkg::VIEW_SEGMENT);
      chk(all_digits, 32'h3f3f3f77);
      setup('0, 3'h0, iotsd_pkg::ITEM_SLAVE_QUAD_RATE, iotsd_pkg::VIEW_SEGMENT);
      chk(shown_value, 32'h5);
      setup('0, 3'h0, iotsd_pkg::ITEM_SLAVE_INDEX_RATE,
         iotsd_pkg::VIEW_SEGMENT);
      chk(shown_value, 32'h4);
      @(posedge clk);
      enc_en <= 3'h2;
      repeat (3 * GATE) @(posedge clk);
      #1;
      chk(shown_value, 32'h0);
      setup('0, 3'h0, iotsd_pkg::ITEM_REF_INDEX_RATE, iotsd_pkg::VIEW_SEGMENT);
      chk(shown_value, 32'h0);
      $display("test rates done");
   endtask
   task automatic t_timer();
      @(posedge clk);
      for (int i = 0; i < 16; i++) begin
         step_values[i] <= 16'ha5c0 + 16'(i);
      end
      for (int s = 0; s < 16; s += 5) begin
         @(posedge clk);
         logic_timer_select <= 4'(s);
         setup('0, 3'h0, iotsd_pkg::ITEM_LOGIC_TIMER, iotsd_pkg::VIEW_SEGMENT);
         chk(shown_value, 32'ha5c0 + s);
      end
      chk(all_digits, 32'h776d3971);
      $display("test timer done");
   endtask
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      t_status();
      t_comm();
      t_hex();
      t_rates();
      t_timer();
      print_verdict();
   end
endmodule
